/* ocs_scheme.sv */
// Overcurrent teleprotection scheme logic with APB register access
`timescale 1ns/1ns
module ocs_scheme #(
  parameter int TICK_CNT = ocs_pkg::TICK_CYCLES,
  parameter bit HAS_REV_IN = 1'b1
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ocs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Relay pins and weak infeed logic
  input wire ocs_pkg::ocs_pins_t pins_in,
  input wire logic weak_infeed_trip,
  // Scheme outputs
  output logic channel_transmit,
  output logic scheme_trip,
  output logic reverse_pickup,
  output logic irq
);
  import ocs_pkg::*;

  ocs_state_t r_reg;
  ocs_state_t r_next;

  logic under;
  logic over;
  logic rx;
  logic blk;
  logic ob_start;
  logic act;
  logic trip_c;
  logic run;
  logic wr;
  logic rd_setup;
  logic [1:0] ev;
  logic [1:0] w1c;
  logic [ocs_pkg::ADDR_W-1:0] a;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  assign pready = 1'b1;
  assign prdata = r_reg.prdata;
  assign pslverr = r_reg.pslverr;
  assign channel_transmit = r_reg.tx;
  assign scheme_trip = r_reg.trip;
  assign reverse_pickup = r_reg.rev;
  assign irq = |(r_reg.ists & r_reg.imask);

  always_comb begin
    r_next = r_reg;
    a = paddr;
    wr = psel & penable & pwrite;
    rd_setup = psel & ~penable;
    w1c = 2'h0;

    // Pin inputs: three stages, a change counts once stages 2 and 3 agree
    r_next.s1 = pins_in;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.filt = ocs_pins_t'((r_reg.s2 & ~(r_reg.s2 ^ r_reg.s3))
                  | (r_reg.filt & (r_reg.s2 ^ r_reg.s3)));

    // Free-running millisecond tick
    if (r_reg.ms_cnt >= 20'(TICK_CNT - 1)) begin
      r_next.ms_cnt = 20'h00000;
      r_next.tick = 1'b1;
    end else begin
      r_next.ms_cnt = r_reg.ms_cnt + 20'h00001;
      r_next.tick = 1'b0;
    end

    // Element selection
    under = r_reg.elem_sel ? r_reg.filt.neg_el1 : r_reg.filt.gnd_el1;
    over = r_reg.elem_sel ? r_reg.filt.neg_el2 : r_reg.filt.gnd_el2;
    if (HAS_REV_IN) begin
      r_next.rev = r_reg.filt.reverse_pickup_in;
    end else begin
      r_next.rev = r_reg.elem_sel ? r_reg.filt.neg_el2
                   : r_reg.filt.ground_inst;
    end
    rx = r_reg.filt.channel_receive;
    blk = r_reg.filt.channel_trip_block_input;

    // Open breaker transmission delay, cleared as soon as a pole closes
    ob_start = r_reg.open_breaker_send_enable & (&r_reg.filt.pole_open);
    if (!ob_start) begin
      r_next.ob_cnt = 16'h0000;
      r_next.ob_ok = 1'b0;
    end else begin
      if (r_reg.tick && r_reg.ob_cnt < OPEN_BREAKER_SEND_DELAY_MS) begin
        r_next.ob_cnt = r_reg.ob_cnt + 16'h0001;
      end
      r_next.ob_ok = (r_reg.ob_cnt == OPEN_BREAKER_SEND_DELAY_MS);
    end

    // Reception must stand for the safety time; noise restarts it
    if (!rx) begin
      r_next.sec_cnt = 16'h0000;
      r_next.rx_acc = 1'b0;
    end else begin
      if (r_reg.tick && r_reg.sec_cnt < r_reg.receive_safety_time) begin
        r_next.sec_cnt = r_reg.sec_cnt + 16'h0001;
      end
      r_next.rx_acc = (r_reg.sec_cnt >= r_reg.receive_safety_time);
    end

    // Scheme decode; any other scheme leaves transmit and trip off
    case (r_reg.scheme)
      SCH_PUR: begin
        act = under | (over & rx) | r_reg.ob_ok;
        trip_c = under | (rx & over)
                 | (weak_infeed_trip
                    & (r_reg.weak_infeed_output_mode == WI_ECHO_TRIP));
        run = 1'b1;
      end
      SCH_DTT: begin
        act = under | r_reg.ob_ok;
        trip_c = r_reg.rx_acc;
        run = 1'b1;
      end
      default: begin
        act = 1'b0;
        trip_c = 1'b0;
        run = 1'b0;
      end
    endcase

    // Carrier minimum time restarts on each new activation
    r_next.act_prev = act;
    if (act && !r_reg.act_prev) begin
      r_next.carr_cnt = r_reg.carrier_min_time;
    end else if (r_reg.tick && r_reg.carr_cnt != 16'h0000) begin
      r_next.carr_cnt = r_reg.carr_cnt - 16'h0001;
    end
    r_next.tx = run & ~blk & (act | (r_reg.carr_cnt != 16'h0000));
    r_next.trip = run & ~blk & trip_c;

    // Register writes
    if (wr) begin
      case (a)
        CTRL_OFS: begin
          r_next.scheme = ocs_scheme_t'(pwdata[CTRL_SCHEME_LSB +: 3]);
          r_next.elem_sel = pwdata[CTRL_ELEM_BIT];
          r_next.open_breaker_send_enable = pwdata[CTRL_OBSEND_BIT];
          r_next.weak_infeed_output_mode =
            ocs_wi_mode_t'(pwdata[CTRL_WIMODE_LSB +: 2]);
        end
        CARR_OFS: begin
          r_next.carrier_min_time = pwdata[15:0];
        end
        SAFE_OFS: begin
          r_next.receive_safety_time = pwdata[15:0];
        end
        ISTS_OFS: begin
          w1c = pwdata[1:0];
        end
        IMSK_OFS: begin
          r_next.imask = pwdata[1:0];
        end
        default: begin
          r_next.imask = r_reg.imask;
        end
      endcase
    end

    // Sticky events; a new event beats a clear in the same cycle
    ev = 2'h0;
    ev[IRQ_TX_BIT] = r_next.tx & ~r_reg.tx;
    ev[IRQ_TRIP_BIT] = r_next.trip & ~r_reg.trip;
    r_next.ists = (r_reg.ists & ~w1c) | ev;

    // Read data latched in the setup cycle, ready in the access cycle
    if (rd_setup) begin
      r_next.pslverr = 1'b0;
      case (a)
        CTRL_OFS: begin
          r_next.prdata = {25'h0000000, r_reg.weak_infeed_output_mode,
                           r_reg.open_breaker_send_enable,
                           r_reg.elem_sel, r_reg.scheme};
        end
        CARR_OFS: begin
          r_next.prdata = {16'h0000, r_reg.carrier_min_time};
        end
        SAFE_OFS: begin
          r_next.prdata = {16'h0000, r_reg.receive_safety_time};
        end
        STAT_OFS: begin
          r_next.prdata = {25'h0000000, r_reg.ob_ok, r_reg.rx_acc, r_reg.rev,
                           r_reg.trip, r_reg.tx, 2'h0};
        end
        ISTS_OFS: begin
          r_next.prdata = {30'h00000000, r_reg.ists};
        end
        IMSK_OFS: begin
          r_next.prdata = {30'h00000000, r_reg.imask};
        end
        default: begin
          r_next.prdata = 32'h00000000;
          r_next.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.scheme <= SCH_NONE;
      r_reg.weak_infeed_output_mode <= WI_OFF;
      r_reg.carrier_min_time <= CARR_RST;
      r_reg.receive_safety_time <= SAFE_RST;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // Output checks look one enabled edge ahead, as outputs are registered
  property p_none_quiet;
    ce && !run |=> !channel_transmit && !scheme_trip;
  endproperty
  AST_NONE_QUIET: assert property (p_none_quiet)
    else $error("Outputs active with no scheme selected");

  property p_block_mute;
    ce && blk |=> !channel_transmit && !scheme_trip;
  endproperty
  AST_BLOCK_MUTE: assert property (p_block_mute)
    else $error("Outputs active while blocked");

  property p_pur_under;
    ce && r_reg.scheme == SCH_PUR && under && !blk
      |=> channel_transmit && scheme_trip;
  endproperty
  AST_PUR_UNDER: assert property (p_pur_under)
    else $error("Underreach pickup did not trip and transmit");

  property p_pur_elem;
    ce && r_reg.scheme == SCH_PUR && !blk && r_reg.elem_sel
      && r_reg.filt.neg_el1 |=> channel_transmit;
  endproperty
  AST_PUR_ELEM: assert property (p_pur_elem)
    else $error("Negative element 1 not used as underreach");

  property p_pur_trip;
    ce && r_reg.scheme == SCH_PUR && rx && over && !blk |=> scheme_trip;
  endproperty
  AST_PUR_TRIP: assert property (p_pur_trip)
    else $error("Reception with overreach did not trip");

  property p_dtt_safe;
    ce && r_reg.scheme == SCH_DTT && !r_reg.rx_acc |=> !scheme_trip;
  endproperty
  AST_DTT_SAFE: assert property (p_dtt_safe)
    else $error("Transfer trip before the safety time");

  property p_dtt_trip;
    ce && r_reg.scheme == SCH_DTT && r_reg.rx_acc && !blk |=> scheme_trip;
  endproperty
  AST_DTT_TRIP: assert property (p_dtt_trip)
    else $error("Accepted reception did not trip");

  property p_dtt_act;
    ce && r_reg.scheme == SCH_DTT && r_reg.ob_ok && !blk
      |=> channel_transmit;
  endproperty
  AST_DTT_ACT: assert property (p_dtt_act)
    else $error("Open breaker did not transmit");

  property p_carr_hold;
    ce && run && !blk && r_reg.carr_cnt != 16'h0000 |=> channel_transmit;
  endproperty
  AST_CARR_HOLD: assert property (p_carr_hold)
    else $error("Transmit dropped before carrier time");

  property p_ob_delay;
    r_reg.ob_ok |-> r_reg.ob_cnt == OPEN_BREAKER_SEND_DELAY_MS;
  endproperty
  AST_OB_DELAY: assert property (p_ob_delay)
    else $error("Open breaker send before its delay");

  property p_ob_reset;
    ce && !ob_start |=> r_reg.ob_cnt == 16'h0000 && !r_reg.ob_ok;
  endproperty
  AST_OB_RESET: assert property (p_ob_reset)
    else $error("Open breaker timer kept running");

  property p_sec_reset;
    ce && !rx |=> r_reg.sec_cnt == 16'h0000 && !r_reg.rx_acc;
  endproperty
  AST_SEC_RESET: assert property (p_sec_reset)
    else $error("Safety timer kept running");

  property p_tick_range;
    r_reg.ms_cnt <= 20'(TICK_CNT - 1);
  endproperty
  AST_TICK_RANGE: assert property (p_tick_range)
    else $error("Tick divider out of range");

  property p_rev_follow;
    ce && HAS_REV_IN |=> reverse_pickup == $past(r_reg.filt.reverse_pickup_in);
  endproperty
  AST_REV_FOLLOW: assert property (p_rev_follow)
    else $error("Reverse pickup does not follow its input");

  // The transmit status bit may only go away by a write of one
  property p_sticky;
    ce && r_reg.ists[IRQ_TX_BIT] && !w1c[IRQ_TX_BIT]
      |=> r_reg.ists[IRQ_TX_BIT];
  endproperty
  AST_STICKY_HOLD: assert property (p_sticky)
    else $error("Status bit lost without a clear");

  // Main scenarios
  COV_PUR_TRIP: cover property (
    r_reg.scheme == SCH_PUR && scheme_trip
  );

  COV_DTT_TRIP: cover property (
    r_reg.scheme == SCH_DTT && scheme_trip
  );

  COV_OB_SEND: cover property (
    r_reg.ob_ok && channel_transmit
  );

  COV_BLOCKED: cover property (
    blk && run && (under | rx)
  );

  COV_IRQ: cover property (
    irq
  );

endmodule

/* ocs_pkg.sv */
// Constants, types and state layout of the overcurrent scheme block
// Operation
// - Select one scheme; only that scheme runs
// - Underreach/overreach from ground or negative elements
// - Reverse element from input or element mux
// - Permissive underreach pickup trips and transmits
// - Permissive underreach channel activation conditions
// - Permissive underreach trip on reception with overreach, or infeed
// - Transmit held at least carrier time
// - Open breaker transmission delayed 100 ms
// - Block input suppresses trip and transmit
// - Direct transfer trips on reception alone
// - Direct transfer activation: underreach or breaker
// - Reception accepted after safety time only in direct transfer
package ocs_pkg;

  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [15:0] OPEN_BREAKER_SEND_DELAY_MS = 16'h0064;

  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] CARR_OFS = 8'h04;
  localparam logic [7:0] SAFE_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam logic [7:0] ISTS_OFS = 8'h10;
  localparam logic [7:0] IMSK_OFS = 8'h14;

  localparam int CTRL_SCHEME_LSB = 0;
  localparam int CTRL_ELEM_BIT = 3;
  localparam int CTRL_OBSEND_BIT = 4;
  localparam int CTRL_WIMODE_LSB = 5;
  localparam int IRQ_TX_BIT = 0;
  localparam int IRQ_TRIP_BIT = 1;

  localparam logic [15:0] CARR_RST = 16'h0032;
  localparam logic [15:0] SAFE_RST = 16'h0014;

  typedef enum logic [2:0] {
    SCH_NONE = 3'h0,
    SCH_PUR = 3'h1,
    SCH_DTT = 3'h2,
    SCH_POR = 3'h3,
    SCH_UNB = 3'h4,
    SCH_BLK = 3'h5
  } ocs_scheme_t;

  typedef enum logic [1:0] {
    WI_OFF = 2'h0,
    WI_ECHO = 2'h1,
    WI_ECHO_TRIP = 2'h2
  } ocs_wi_mode_t;

  typedef struct packed {
    logic channel_trip_block_input;
    logic [2:0] pole_open;
    logic channel_receive;
    logic reverse_pickup_in;
    logic ground_inst;
    logic neg_el2;
    logic neg_el1;
    logic gnd_el2;
    logic gnd_el1;
  } ocs_pins_t;

  typedef struct packed {
    ocs_pins_t s1;
    ocs_pins_t s2;
    ocs_pins_t s3;
    ocs_pins_t filt;
    logic [19:0] ms_cnt;
    logic tick;
    logic [15:0] ob_cnt;
    logic ob_ok;
    logic [15:0] carr_cnt;
    logic [15:0] sec_cnt;
    logic rx_acc;
    logic act_prev;
    logic tx;
    logic trip;
    logic rev;
    ocs_scheme_t scheme;
    logic elem_sel;
    logic open_breaker_send_enable;
    ocs_wi_mode_t weak_infeed_output_mode;
    logic [15:0] carrier_min_time;
    logic [15:0] receive_safety_time;
    logic [1:0] ists;
    logic [1:0] imask;
    logic [31:0] prdata;
    logic pslverr;
  } ocs_state_t;

endpackage

/* ocs_remote.sv */
// Remote relay model driving the carrier receive line
`timescale 1ns/1ns
module ocs_remote #(
  parameter int DLY = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Command and carrier
  input wire logic send,
  output logic rx
);
  logic [7:0] cnt_reg;
  // Carrier comes up only after the remote pickup delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 8'h00;
    end else if (!send) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg != DLY[7:0]) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  assign rx = (cnt_reg == DLY[7:0]);
endmodule

/* test_overcurrent_teleprotection_schemes.sv */
// Self-checking bench of the overcurrent scheme block
`timescale 1ns/1ns
module test_overcurrent_teleprotection_schemes;
  import ocs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic wit = 0, send = 0, rx, pready, pslverr, tx, trip, rev, irq, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  ocs_pins_t pins = '0, pv;
  int n_mismatch = 0, checked = 0;
  always #10 pclk = ~pclk;
  always_comb begin
    pv = pins;
    pv.channel_receive = rx;
  end
  // Ten cycles per tick keeps the 100 ms wait short
  ocs_scheme #(.TICK_CNT(10)) i_ocs_scheme (.pclk(pclk),
    .presetn(presetn), .ce(1'h1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins_in(pv),
    .weak_infeed_trip(wit), .channel_transmit(tx), .scheme_trip(trip),
    .reverse_pickup(rev), .irq(irq));
  ocs_remote i_ocs_remote (.pclk(pclk), .presetn(presetn),
    .send(send), .rx(rx));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // A wait that runs out ends the run at once
  task wt(input int n, input bit s, input logic v);
    for (int i = 0; i < n && ((s ? trip : tx) !== v); i++) @(posedge pclk);
    if ((s ? trip : tx) !== v) begin
      n_mismatch++;
      $display("[ERR] wait exp %b got %b", v, s ? trip : tx);
      results();
    end
  endtask
  // Request held until pready is seen high at a rising edge, for at most 20 edges
  task apb(input logic [7:0] a, input logic [31:0] d, input bit w = 1'b1);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (i == 20) begin
      n_mismatch++;
      $display("[ERR] pready exp 1 got 0");
      results();
    end
  endtask
  task t_none();
    apb(CTRL_OFS, 32'h00000000);
    apb(8'hFC, 32'h00000000, 1'b0);
    chk("pslverr", 1'h1, err);
    pins.gnd_el1 <= 1'h1;
    pins.reverse_pickup_in <= 1'h1;
    repeat (100) @(posedge pclk);
    chk("tx", 1'h0, tx);
    chk("trip", 1'h0, trip);
    chk("rev", 1'h1, rev);
    pins <= '0;
    $display("t_none done");
  endtask
  task t_pur();
    apb(CARR_OFS, 32'h00000005);
    apb(CTRL_OFS, 32'h00000041);
    apb(CTRL_OFS, 32'h00000000, 1'b0);
    chk("ctrl_rd", 32'h00000041, rd);
    chk("pslverr_ok", 1'h0, err);
    pins.gnd_el1 <= 1'h1;
    wt(50, 0, 1'h1);
    chk("tx", 1'h1, tx);
    pins.gnd_el1 <= 1'h0;
    repeat (20) @(posedge pclk);
    chk("tx_hold", 1'h1, tx);
    wt(200, 0, 1'h0);
    chk("tx_end", 1'h0, tx);
    chk("irq_mask", 1'h0, irq);
    apb(IMSK_OFS, 32'h00000003);
    repeat (2) @(posedge pclk);
    chk("irq", 1'h1, irq);
    apb(ISTS_OFS, 32'h00000000, 1'b0);
    chk("ists_rd", 32'h00000003, rd);
    apb(ISTS_OFS, 32'h00000003);
    repeat (2) @(posedge pclk);
    chk("irq_clr", 1'h0, irq);
    send <= 1'h1;
    pins.gnd_el2 <= 1'h1;
    wt(50, 1, 1'h1);
    chk("trip", 1'h1, trip);
    chk("tx_or", 1'h1, tx);
    pins.channel_trip_block_input <= 1'h1;
    wt(50, 1, 1'h0);
    chk("trip_blk", 1'h0, trip);
    chk("tx_blk", 1'h0, tx);
    pins <= '0;
    send <= 1'h0;
    repeat (10) @(posedge pclk);
    wit <= 1'h1;
    wt(50, 1, 1'h1);
    chk("trip_wi", 1'h1, trip);
    wit <= 1'h0;
    $display("t_pur done");
  endtask
  task t_dtt();
    apb(SAFE_OFS, 32'h00000003);
    apb(CTRL_OFS, 32'h00000002);
    send <= 1'h1;
    repeat (15) @(posedge pclk);
    chk("trip_early", 1'h0, trip);
    wt(100, 1, 1'h1);
    chk("trip", 1'h1, trip);
    send <= 1'h0;
    wt(100, 1, 1'h0);
    chk("trip_off", 1'h0, trip);
    $display("t_dtt done");
  endtask
  task t_ob();
    apb(CTRL_OFS, 32'h00000012);
    pins.pole_open <= 3'h7;
    repeat (900) @(posedge pclk);
    chk("tx_early", 1'h0, tx);
    wt(200, 0, 1'h1);
    chk("tx", 1'h1, tx);
    apb(STAT_OFS, 32'h00000000, 1'b0);
    chk("stat_rd", 32'h00000044, rd);
    pins <= '0;
    $display("t_ob done");
  endtask
  task results();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    t_none();
    t_pur();
    t_dtt();
    t_ob();
    results();
  end
endmodule
